/* File: sim/core_status_bank_select_regs_tb_top.sv */
// Purpose: Self-checking bench of the core register bank.
// Assumes: Status model ms tracks the flags from reset.
// Notes:   Rotates leave zero flag unchecked until the clear op resyncs it.
`timescale 1ns/1ps
module core_status_bank_select_regs_tb_top;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] ev = 4'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [6:0] fld = 7'h00;
   logic [2:0] op = 3'h0;
   logic [7:0] a = 8'h00;
   logic [7:0] b = 8'h00;
   logic [7:0] ms = 8'h18;
   logic [7:0] r;
   logic [7:0] ad;
   wire  [7:0] res, rdata, dadr, pc_low_byte, pad, pbd;
   wire  [4:0] pch;
   wire        byp;
   integer     failures = 0;
   integer     checks_done = 0;
   integer     seed = 92275;
   // Clock of 40 ns.
   always #20 clock = ~clock;
   csbr_alu_model alu_i (.alu_op(op), .alu_a(a), .alu_b(b), .carry_in(ms[0]), .alu_result(res));
   csbr_core_regs dut (.clock(clock), .rst(rst), .reset_other(ev[0]), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .direct_field(fld), .direct_addr(dadr),
      .alu_op(op), .alu_a(a), .alu_b(b), .alu_result(res), .watchdog_clear_instr(ev[1]),
      .sleep_instr(ev[2]), .watchdog_timeout(ev[3]), .pc_high_out(pch), .pc_low_out(pc_low_byte),
      .timer_prescale_bypass(byp), .port_a_dir_out(pad), .port_b_dir_out(pbd));
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Bus cycles; strobes last one cycle.
   task automatic wr_reg(input logic [7:0] ga, input logic [7:0] d);
      @(posedge clock);
      addr <= ga;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] ga, input logic [7:0] e,
                         input logic [7:0] m);
      @(posedge clock);
      addr <= ga;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check(nm, rdata & m, e & m);
   endtask
   // Event pulse and its effect on the modelled flags.
   task automatic pulse(input logic [3:0] e);
      @(posedge clock);
      ev <= e;
      @(posedge clock);
      ev <= 4'h0;
      // A reset in the same cycle wins over every event.
      if (e[0]) ms[7:5] = 3'h0;
      else
      begin
         if (e[1]) ms[4:3] = 2'b11;
         if (e[2]) ms[4:3] = 2'b10;
         if (e[3]) ms[4] = 1'b0;
      end
   endtask
   // ALU operation with a same-cycle status write, then read back.
   task automatic alu(input logic [2:0] o, input logic dir);
      logic [7:0] x;
      logic [7:0] y;
      logic [8:0] s;
      logic [4:0] d;
      x = dir ? 8'h88 : 8'($random(seed));
      y = dir ? 8'h78 : 8'($random(seed));
      s = {1'b0, x} + {1'b0, (o == 3'h2) ? ~y : y} + {8'h00, o == 3'h2};
      d = {1'b0, x[3:0]} + {1'b0, (o == 3'h2) ? ~y[3:0] : y[3:0]} + {4'h0, o == 3'h2};
      @(posedge clock);
      op <= o;
      a <= x;
      b <= y;
      addr <= 8'h83;
      wdata <= 8'hff;
      wr <= 1'b1;
      @(posedge clock);
      op <= 3'h0;
      wr <= 1'b0;
      case (o)
         3'h1, 3'h2: ms[2:0] = {s[7:0] == 8'h00, d[4], s[8]};
         3'h3: ms[2] = (x & y) == 8'h00;
         3'h4: ms[0] = x[7];
         3'h5: ms[0] = x[0];
         default: ms[2] = 1'b1;
      endcase
      ms[7:5] = (o == 3'h6) ? 3'h0 : 3'h7;
      rd_chk("status", 8'h83, ms, (o[2] && !o[1]) ? 8'hfb : 8'hff);
      check("daddr", dadr, {ms[5], fld});
   endtask
   // Main sequence.
   initial
   begin
      fld = 7'($random(seed));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd_chk("option", 8'h81, 8'hff, 8'hff);
      rd_chk("pcl", 8'h82, 8'h00, 8'hff);
      rd_chk("status", 8'h83, ms, 8'hff);
      rd_chk("dir_a", 8'h85, 8'h1f, 8'hff);
      rd_chk("dir_b", 8'h86, 8'hff, 8'hff);
      rd_chk("latch", 8'h0a, 8'h00, 8'hff);
      check("bypass", {7'h00, byp}, 8'h01);
      $display("test reset done");
      r = 8'($random(seed));
      wr_reg(8'h83, r);
      ms = {r[7:5], ms[4:3], r[2:0]};
      rd_chk("status", 8'h83, ms, 8'hff);
      for (int i = 0; i < 6; i++)
         for (int o = 1; o < 7; o++)
            alu(3'(o), i == 0);
      $display("test flags done");
      wr_reg(8'h85, 8'h00);
      wr_reg(8'h86, 8'h00);
      wr_reg(8'h0a, r);
      rd_chk("latch", 8'h0a, r & 8'h1f, 8'hff);
      check("pc_hi", {3'h0, pch}, r & 8'h1f);
      wr_reg(8'h81, 8'hf7);
      rd_chk("option", 8'h81, 8'hf7, 8'hff);
      check("bypass", {7'h00, byp}, 8'h00);
      foreach (r[k])
      begin
         ad = {4'h8, k[3:0]};
         pulse((k < 4) ? 4'(1 << k) : ad[3:0] | 4'h4);
         rd_chk("status", 8'h83, ms, 8'hff);
      end
      check("dir_a", pad, 8'h1f);
      check("dir_b", pbd, 8'hff);
      check("pc_hi", {3'h0, pch}, 8'h00);
      check("bypass", {7'h00, byp}, 8'h01);
      wr_reg(8'h83, ms & 8'h1f);
      rd_chk("status", 8'h83, ms & 8'h1f, 8'hff);
      $display("test events done");
      for (int k = 0; k < 4; k++)
      begin
         r = 8'($random(seed));
         ad = (k == 3) ? 8'h4f : 8'h0c + 8'(k * 21);
         wr_reg(ad, r);
         rd_chk("store", ad | 8'h80, r, 8'hff);
      end
      wr_reg(8'h87, 8'h5a);
      rd_chk("unmapped", 8'h87, 8'h00, 8'hff);
      $display("test storage done");
      stop_test();
   end
   // Watchdog against a hang.
   initial
   begin
      repeat (3000) @(posedge clock);
      failures = failures + 1;
      stop_test();
   end
endmodule
bind csbr_core_regs csbr_core_regs_asserts chk_i (.clock(clock), .rst(rst),
   .reset_other(reset_other), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .watchdog_clear_instr(watchdog_clear_instr),
   .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout), .rdata(rdata),
   .direct_addr(direct_addr), .pc_high_out(pc_high_out), .pc_low_out(pc_low_out),
   .timer_prescale_bypass(timer_prescale_bypass), .port_a_dir_out(port_a_dir_out),
   .port_b_dir_out(port_b_dir_out));

/* File: sim/csbr_alu_model.sv */
// Purpose: Execution-side model that feeds the operation result to the bank.
// Assumes: Operands come from the bench; purely combinational.
// Notes:   Only the result is made here; the flags are the bank's job.
`timescale 1ns/1ps
module csbr_alu_model
(
   // Operation.
   input  wire logic [2:0] alu_op,
   input  wire logic [7:0] alu_a,
   input  wire logic [7:0] alu_b,
   input  wire logic       carry_in,
   // Result.
   output logic      [7:0] alu_result
);
   // Result of each operation; clear and idle give zero.
   always_comb
   begin
      case (alu_op)
         3'h1: alu_result = alu_a + alu_b;
         3'h2: alu_result = alu_a + ~alu_b + 8'h01;
         3'h3: alu_result = alu_a & alu_b;
         3'h4: alu_result = {alu_a[6:0], carry_in};
         3'h5: alu_result = {carry_in, alu_a[7:1]};
         default: alu_result = 8'h00;
      endcase
   end
endmodule

/* File: sim/csbr_core_regs_asserts.sv */
// Purpose: Port checks of the core register bank.
// Assumes: Sees only top module ports; one clock.
// Notes:   Read-back checks wait one quiet cycle, as the bench does.
`timescale 1ns/1ps
module csbr_core_regs_asserts
(
   // Inputs.
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       reset_other,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [2:0] alu_op,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic       watchdog_clear_instr,
   input wire logic       sleep_instr,
   input wire logic       watchdog_timeout,
   // Outputs.
   input wire logic [7:0] rdata,
   input wire logic [7:0] direct_addr,
   input wire logic [4:0] pc_high_out,
   input wire logic [7:0] pc_low_out,
   input wire logic       timer_prescale_bypass,
   input wire logic [7:0] port_a_dir_out,
   input wire logic [7:0] port_b_dir_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [8:0] sum9;
   logic       add_c;
   logic       w5;
   logic       w3;
   logic       quiet;
   logic       st_rd;
   // Helper terms; the carry is worked out apart from the bank.
   assign sum9  = {1'b0, alu_a} + {1'b0, alu_b};
   assign add_c = sum9[8];
   assign w5    = wdata[5] && alu_op != 3'h6;
   assign w3    = wdata[3];
   assign quiet = !reset_other && !wr && alu_op == 3'h0 && !watchdog_clear_instr
                  && !sleep_instr && !watchdog_timeout;
   assign st_rd = rd && addr == 8'h83 && !reset_other;
   sequence s_then_rd;
      quiet ##1 st_rd;
   endsequence
   chk_dir_reset: assert property (reset_other |=> port_a_dir_out == 8'h1f
      && port_b_dir_out == 8'hff) else $error("port direction not all ones");
   chk_pc_reset: assert property (reset_other |=> pc_high_out == 5'h00
      && pc_low_out == 8'h00) else $error("program counter bytes not cleared");
   chk_latch_write: assert property (wr && addr == 8'h0a && !reset_other
      |=> {3'h0, pc_high_out} == ($past(wdata) & 8'h1f)) else $error("latch not loaded");
   chk_bank_bit: assert property (wr && addr == 8'h83 && !reset_other
      |=> direct_addr[7] == $past(w5)) else $error("bank bit not in address");
   chk_bypass_bit: assert property (wr && addr == 8'h81 && !reset_other
      |=> timer_prescale_bypass == $past(w3)) else $error("bypass wrong");
   chk_add_carry: assert property (alu_op == 3'h1 && !reset_other ##1 s_then_rd
      |=> rdata[0] == $past(add_c, 3)) else $error("add carry wrong");
   chk_clear_op: assert property (alu_op == 3'h6 && wr && addr == 8'h83 && !reset_other
      ##1 s_then_rd |=> rdata[7:5] == 3'h0 && rdata[2]) else $error("clear op wrong");
   chk_timeout_flag: assert property (watchdog_timeout && !reset_other ##1 s_then_rd
      |=> !rdata[4]) else $error("expiry flag not cleared");
   chk_sleep_flag: assert property (sleep_instr && !watchdog_timeout && !reset_other
      ##1 s_then_rd
      |=> rdata[4:3] == 2'b10) else $error("sleep flags wrong");
endmodule

/* File: verilog/csbr_core_regs.sv */
// Purpose: Core status, bank select, program counter latch and bank-1 registers.
// Assumes: One clock; the execution unit presents one operation per cycle.
// Notes:   Power-on is rst; other resets come from reset_other.
//
// Behaviour
// - Status write to Z, DC, C is dropped when the operation sets flags.
// - Watchdog-expiry and sleep flags ignore every software write.
// - Clearing status clears the upper three bits and sets zero.
// - Bank select 0 picks 00h-7Fh, 1 picks 80h-FFh; only low bit used.
// - Watchdog-expiry flag bit 4: one on power-up, clear or sleep; zero on timeout.
// - Sleep flag bit 3: one on power-up or clear; zero on sleep.
// - Zero flag bit 2 set when result is zero, else cleared.
// - Nibble flag bit 1 is carry out of bit 3; inverted borrow on subtract.
// - Carry flag bit 0 is carry out of bit 7 on addition.
// - Subtraction adds the two's complement, so borrows read inverted.
// - Rotate through carry loads carry with the bit shifted out.
// - Master-clear reset leaves the expiry and sleep flags alone.
// - Other resets keep registers marked unchanged.
// - Counter upper bits unreadable; latch goes to counter, never back.
// - Every reset sets both port direction registers to all ones.
// - With the prescaler on the watchdog, the timer counts one to one.
// - General storage in bank 1 aliases the same bank 0 bytes.
`timescale 1ns/1ps
`include "csbr_defines.svh"

module csbr_core_regs
#(
   parameter int DATA_W = 8
)
(
   // Clock and resets.
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        reset_other,
   // Register port.
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   // Direct addressing from the instruction.
   input  wire logic [6:0]  direct_field,
   output logic      [7:0]  direct_addr,
   // ALU operation.
   input  wire logic [2:0]  alu_op,
   input  wire logic [7:0]  alu_a,
   input  wire logic [7:0]  alu_b,
   input  wire logic [7:0]  alu_result,
   // Power management events.
   input  wire logic        watchdog_clear_instr,
   input  wire logic        sleep_instr,
   input  wire logic        watchdog_timeout,
   // Program counter, timer and port direction controls.
   output logic      [4:0]  pc_high_out,
   output logic      [7:0]  pc_low_out,
   output logic             timer_prescale_bypass,
   output logic      [7:0]  port_a_dir_out,
   output logic      [7:0]  port_b_dir_out
);

   // ****************************************************************
   // Checks and helpers
   // ****************************************************************
   // The flag and read paths are written for bytes; other widths are refused at elaboration.
   if (DATA_W != 8)
   begin : g_width_check
      $error("csbr_core_regs serves 8-bit data only.");
   end

   // True for an operation whose result drives the arithmetic flags.
   function automatic logic sets_flags(input logic [2:0] op);
      sets_flags = (op != `CSBR_OP_NONE);
   endfunction

   // Index of general storage for a data address, bank bit ignored.
   function automatic logic [6:0] gpr_index(input logic [7:0] a);
      gpr_index = a[6:0] - `CSBR_ADDR_GPR_LO;
   endfunction

   // True when the low seven address bits hit general storage.
   function automatic logic is_gpr(input logic [7:0] a);
      is_gpr = (a[6:0] >= `CSBR_ADDR_GPR_LO) && (a[6:0] <= `CSBR_ADDR_GPR_HI);
   endfunction

   csbr_pkg::csbr_state_t   st_ff;
   csbr_pkg::csbr_state_t   nxt_st;
   csbr_pkg::csbr_rst_kind_t rkind;
   logic [8:0]              sum;
   logic [4:0]              nib;
   logic [7:0]              b_eff;
   logic [7:0]              status_rd;

   // ****************************************************************
   // Adder and status view
   // ****************************************************************
   // Subtraction folds into the adder via two's complement of b.
   assign b_eff     = (alu_op == `CSBR_OP_SUB) ? (~alu_b) : alu_b;
   assign sum       = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, (alu_op == `CSBR_OP_SUB)};
   assign nib       = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]}
                    + {4'h0, (alu_op == `CSBR_OP_SUB)};
   assign status_rd = {st_ff.upper3, st_ff.wdt_expiry, st_ff.sleep_ent,
                       st_ff.zero, st_ff.nib_ovf, st_ff.msb_ovf};
   assign rkind     = rst ? csbr_pkg::CSBR_RST_POR
                    : (reset_other ? csbr_pkg::CSBR_RST_OTHER : csbr_pkg::CSBR_RST_NONE);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // One process computes the whole next state of the bank.
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.rdata = 8'h00;
      // Software writes; read-only flags are never assigned here.
      if (wr)
      begin
         case (addr)
            `CSBR_ADDR_STATUS:
            begin
               nxt_st.upper3 = wdata[`CSBR_ST_IRP:`CSBR_ST_RP0];
               // Arithmetic flags take the write only when no operation is presented.
               if (!sets_flags(alu_op))
               begin
                  nxt_st.zero    = wdata[`CSBR_ST_Z];
                  nxt_st.nib_ovf = wdata[`CSBR_ST_DC];
                  nxt_st.msb_ovf = wdata[`CSBR_ST_C];
               end
            end
            `CSBR_ADDR_OPTION:  nxt_st.option  = wdata;
            `CSBR_ADDR_PCL:     nxt_st.pc_low_byte     = wdata;
            `CSBR_ADDR_PC_HIGH_LATCH:  nxt_st.pc_high_latch  = wdata[4:0];
            `CSBR_ADDR_POINTER: nxt_st.pointer = wdata;
            `CSBR_ADDR_DIR_A:   nxt_st.dir_a   = wdata[4:0];
            `CSBR_ADDR_DIR_B:   nxt_st.dir_b   = wdata;
            `CSBR_ADDR_INTCTL:  nxt_st.intctl  = wdata;
            `CSBR_ADDR_NVM1:    nxt_st.nvm1    = wdata[4:0];
            default:
            begin
               // Bank 1 storage aliases bank 0 storage.
               if (is_gpr(addr))
                  nxt_st.general_storage_byte[gpr_index(addr)] = wdata;
            end
         endcase
      end
      // Flags from the operation result.
      case (alu_op)
         `CSBR_OP_ADD, `CSBR_OP_SUB:
         begin
            nxt_st.zero    = (sum[7:0] == 8'h00);
            nxt_st.nib_ovf = nib[4];
            nxt_st.msb_ovf = sum[8];
         end
         `CSBR_OP_LOGIC:
            nxt_st.zero = (alu_result == 8'h00);
         `CSBR_OP_ROTL:
            nxt_st.msb_ovf = alu_a[7];
         `CSBR_OP_ROTR:
            nxt_st.msb_ovf = alu_a[0];
         `CSBR_OP_CLEAR:
         begin
            // Clear of status also wipes the writable upper bits.
            if (wr && addr == `CSBR_ADDR_STATUS)
               nxt_st.upper3 = `CSBR_RST_UPPER3;
            nxt_st.zero = 1'b1;
         end
         default:
         begin
            nxt_st.zero = nxt_st.zero;
         end
      endcase
      // Power management events own the two read-only flags.
      if (watchdog_timeout)
         nxt_st.wdt_expiry = 1'b0;
      else if (watchdog_clear_instr || sleep_instr)
         nxt_st.wdt_expiry = 1'b1;
      if (sleep_instr)
         nxt_st.sleep_ent = 1'b0;
      else if (watchdog_clear_instr)
         nxt_st.sleep_ent = 1'b1;
      // Register reads, answered one cycle later; counter high stays hidden.
      if (rd)
      begin
         case (addr)
            `CSBR_ADDR_STATUS:  nxt_st.rdata = status_rd;
            `CSBR_ADDR_OPTION:  nxt_st.rdata = st_ff.option;
            `CSBR_ADDR_PCL:     nxt_st.rdata = st_ff.pc_low_byte;
            `CSBR_ADDR_PC_HIGH_LATCH:  nxt_st.rdata = {3'h0, st_ff.pc_high_latch};
            `CSBR_ADDR_POINTER: nxt_st.rdata = st_ff.pointer;
            `CSBR_ADDR_DIR_A:   nxt_st.rdata = {3'h0, st_ff.dir_a};
            `CSBR_ADDR_DIR_B:   nxt_st.rdata = st_ff.dir_b;
            `CSBR_ADDR_INTCTL:  nxt_st.rdata = st_ff.intctl;
            `CSBR_ADDR_NVM1:    nxt_st.rdata = {3'h0, st_ff.nvm1};
            default:
            begin
               if (is_gpr(addr))
                  nxt_st.rdata = st_ff.general_storage_byte[gpr_index(addr)];
            end
         endcase
      end
      // Resets: power-on sets everything but storage, others keep unchanged fields.
      case (rkind)
         csbr_pkg::CSBR_RST_POR:
         begin
            nxt_st            = st_ff;
            nxt_st.upper3     = `CSBR_RST_UPPER3;
            nxt_st.wdt_expiry = 1'b1;
            nxt_st.sleep_ent  = 1'b1;
            nxt_st.zero       = 1'b0;
            nxt_st.nib_ovf    = 1'b0;
            nxt_st.msb_ovf    = 1'b0;
            nxt_st.option     = `CSBR_RST_OPTION;
            nxt_st.pc_low_byte        = `CSBR_RST_PCL;
            nxt_st.pc_high_latch     = `CSBR_RST_PC_HIGH_LATCH;
            nxt_st.pointer    = 8'h00;
            nxt_st.dir_a      = `CSBR_RST_DIR_A;
            nxt_st.dir_b      = `CSBR_RST_DIR_B;
            nxt_st.intctl     = `CSBR_RST_INTCTL;
            nxt_st.nvm1       = 5'h00;
            nxt_st.rdata      = 8'h00;
         end
         csbr_pkg::CSBR_RST_OTHER:
         begin
            // Flags, pointer and storage keep their values here.
            nxt_st            = st_ff;
            nxt_st.upper3     = `CSBR_RST_UPPER3;
            nxt_st.option     = `CSBR_RST_OPTION;
            nxt_st.pc_low_byte        = `CSBR_RST_PCL;
            nxt_st.pc_high_latch     = `CSBR_RST_PC_HIGH_LATCH;
            nxt_st.dir_a      = `CSBR_RST_DIR_A;
            nxt_st.dir_b      = `CSBR_RST_DIR_B;
            nxt_st.intctl     = {7'(`CSBR_RST_INTCTL >> 1), st_ff.intctl[0]};
            nxt_st.rdata      = 8'h00;
         end
         default:
         begin
            nxt_st.rdata = nxt_st.rdata;
         end
      endcase
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Storage is not reset so that its contents survive every reset.
   always_ff @(posedge clock)
   begin
      st_ff <= nxt_st;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Only the low bank bit reaches the address.
   assign direct_addr           = {st_ff.upper3[0], direct_field};
   assign rdata                 = st_ff.rdata;
   assign pc_high_out           = st_ff.pc_high_latch;
   assign pc_low_out            = st_ff.pc_low_byte;
   // Timer runs unscaled while the prescaler serves the watchdog.
   assign timer_prescale_bypass = st_ff.option[`CSBR_OPT_PSA];
   assign port_a_dir_out        = {3'h0, st_ff.dir_a};
   assign port_b_dir_out        = st_ff.dir_b;

endmodule

/* File: verilog/csbr_defines.svh */
// Purpose: Offsets, field positions, reset values and encodings of the core register bank.
// Assumes: Included by bare name; definitions only.
// Notes:   Register bus offsets equal the data-memory file addresses.
`ifndef CSBR_DEFINES_SVH
`define CSBR_DEFINES_SVH

// ****************************************************************
// Register file addresses
// ****************************************************************
`define CSBR_ADDR_INDIRECT   8'h80
`define CSBR_ADDR_OPTION     8'h81
`define CSBR_ADDR_PCL        8'h82
`define CSBR_ADDR_STATUS     8'h83
`define CSBR_ADDR_POINTER    8'h84
`define CSBR_ADDR_DIR_A      8'h85
`define CSBR_ADDR_DIR_B      8'h86
`define CSBR_ADDR_NVM1       8'h88
`define CSBR_ADDR_NVM2       8'h89
`define CSBR_ADDR_PC_HIGH_LATCH     8'h0a
`define CSBR_ADDR_INTCTL     8'h0b
`define CSBR_ADDR_GPR_LO     7'h0c
`define CSBR_ADDR_GPR_HI     7'h4f

// ****************************************************************
// Status and option field positions
// ****************************************************************
`define CSBR_ST_IRP          7
`define CSBR_ST_RP1          6
`define CSBR_ST_RP0          5
`define CSBR_ST_TO           4
`define CSBR_ST_PD           3
`define CSBR_ST_Z            2
`define CSBR_ST_DC           1
`define CSBR_ST_C            0
`define CSBR_OPT_PSA         3

// ****************************************************************
// Reset values and general storage size
// ****************************************************************
`define CSBR_RST_OPTION      8'hff
`define CSBR_RST_DIR_A       5'h1f
`define CSBR_RST_DIR_B       8'hff
`define CSBR_RST_PC_HIGH_LATCH      5'h00
`define CSBR_RST_PCL         8'h00
`define CSBR_RST_UPPER3      3'h0
`define CSBR_RST_INTCTL      8'h00
`define CSBR_GPR_COUNT       68

// ****************************************************************
// ALU operation codes
// ****************************************************************
`define CSBR_OP_NONE         3'h0
`define CSBR_OP_ADD          3'h1
`define CSBR_OP_SUB          3'h2
`define CSBR_OP_LOGIC        3'h3
`define CSBR_OP_ROTL         3'h4
`define CSBR_OP_ROTR         3'h5
`define CSBR_OP_CLEAR        3'h6

`endif

/* File: verilog/csbr_pkg.sv */
// Purpose: Types shared by the core register bank.
// Assumes: Constants come from csbr_defines.svh.
// Notes:   Nothing here is imported; users write csbr_pkg::name.
package csbr_pkg;

   // Reset kind seen by the flag logic.
   typedef enum logic [1:0]
   {
      CSBR_RST_NONE  = 2'h0,
      CSBR_RST_POR   = 2'h1,
      CSBR_RST_OTHER = 2'h3
   } csbr_rst_kind_t;

   // Whole state of the bank.
   typedef struct packed
   {
      logic [2:0]             upper3;
      logic                   wdt_expiry;
      logic                   sleep_ent;
      logic                   zero;
      logic                   nib_ovf;
      logic                   msb_ovf;
      logic [7:0]             option;
      logic [7:0]             pc_low_byte;
      logic [4:0]             pc_high_latch;
      logic [7:0]             pointer;
      logic [4:0]             dir_a;
      logic [7:0]             dir_b;
      logic [7:0]             intctl;
      logic [4:0]             nvm1;
      logic [7:0]             rdata;
      logic [67:0][7:0]       general_storage_byte;
   } csbr_state_t;

endpackage
